// ---- verilog/qas_consts.vh ----
// Purpose : shared constants of the quad converter serial sequencer
// Assumes : included by bare name from the design files
// Notes   : counts are in serial clock edges unless named otherwise
`ifndef QAS_CONSTS_VH
`define QAS_CONSTS_VH

// conversion framing, in serial clock edges
`define QAS_EDGES_PER_CONV   5'h10
`define QAS_TRACK_CYCLES     5'h03
`define QAS_HOLD_FALL        5'h04
`define QAS_FIRST_DATA_FALL  5'h05
`define QAS_CONV_CYCLES      5'h0d
`define QAS_CTRL_BITS        5'h08

// result geometry
`define QAS_RES_W            12
`define QAS_RES_MSB_IDX      4'hb
`define QAS_SAR_SEED         12'h800

// control word layout (channel address sits in bits 5..3)
`define QAS_CW_W             8
`define QAS_CW_SEL2_BIT      5
`define QAS_CW_SEL1_BIT      4
`define QAS_CW_SEL0_BIT      3

// channel codes and reset values
`define QAS_CH_INPUT_1       2'h0
`define QAS_CH_INPUT_2       2'h1
`define QAS_CH_INPUT_3       2'h2
`define QAS_CH_INPUT_4       2'h3
`define QAS_CH_RESET         2'h0
`define QAS_CW_RESET         8'h00

// link sampling
`define QAS_SYNC_STAGES      3
`define QAS_SYS_CLK_HZ       50000000

`endif

// ---- verilog/qas_sar.v ----
// Purpose : successive-approximation bit engine driving the trial code
// Assumes : cmp_in is the comparator decision on sys_clk, valid for the
//           trial code presented since the previous step
// Notes   : one decision per step pulse, most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "qas_consts.vh"

module qas_sar
(
  // clock and reset
  input  wire                      sys_clk,
  input  wire                      reset,
  // sequencing
  input  wire                      start,
  input  wire                      step,
  // comparator
  input  wire                      cmp_in,
  // results
  output reg  [`QAS_RES_W-1:0]     trial_code,
  output reg  [`QAS_RES_W-1:0]     result,
  output reg                       done
);

  reg  [3:0]             idx_q;    // bit currently being decided
  reg                    busy_q;   // engine inside a conversion
  reg  [`QAS_RES_W-1:0]  next_c;   // trial code after this step
  integer                i;

  // next trial: keep decided bits, fix current one, try the one below
  always @*
  begin
    next_c = trial_code;
    for (i = 0; i < `QAS_RES_W; i = i + 1)
    begin
      if (i == idx_q)
        next_c[i] = cmp_in;
      else if ((i + 1) == idx_q)
        next_c[i] = 1'b1;
    end
  end

  // step the approximation; a restart always wins over a stale step
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      trial_code <= {`QAS_RES_W{1'b0}};
      result     <= {`QAS_RES_W{1'b0}};
      idx_q      <= 4'h0;
      busy_q     <= 1'b0;
      done       <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        trial_code <= `QAS_SAR_SEED;
        idx_q      <= `QAS_RES_MSB_IDX;
        busy_q     <= 1'b1;
      end
      else if (step && busy_q)
      begin
        trial_code <= next_c;
        if (idx_q == 4'h0)
        begin
          // last bit decided: straight binary code is final
          result <= next_c;
          done   <= 1'b1;
          busy_q <= 1'b0;
        end
        else
          idx_q <= idx_q - 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/qas_seq.v ----
// Purpose : serial interface and conversion sequencer of a four-input
//           12-bit successive-approximation converter
// Assumes : cs_n, sclk and din come from the host, asynchronous to
//           sys_clk; sclk is much slower than sys_clk
// Notes   : there is no reset pin on the real part; reset here models
//           power-up
//           cmp_in comes from the core on sys_clk and is not synchronised
`timescale 1ns/1ps
`default_nettype none
`include "qas_consts.vh"

module qas_seq
(
  // clock and reset
  input  wire                      sys_clk,
  input  wire                      reset,
  // serial link from the host
  input  wire                      cs_n,
  input  wire                      sclk,
  input  wire                      din,
  output reg                       dout_o,
  output reg                       dout_oe_n,
  // analog core control
  input  wire                      cmp_in,
  output reg  [1:0]                chan_sel,
  output reg                       track,
  output reg                       sample_strobe,
  output reg                       power_down,
  output wire [`QAS_RES_W-1:0]     dac_code,
  // digital result
  output wire [`QAS_RES_W-1:0]     result,
  output wire                      result_valid
);

  // channel decode: address bit 2 and the don't-care bits are dropped
  // bits seven, six, five and two to zero never reach the mux
  function [1:0] chan_of;
    input [`QAS_CW_W-1:0] word;
    begin
      chan_of = {word[`QAS_CW_SEL1_BIT], word[`QAS_CW_SEL0_BIT]};
    end
  endfunction

  // three-stage synchronisers for the host pins
  // raw stages first, then the levels that the sequencer trusts
  reg  [`QAS_SYNC_STAGES-1:0] cs_sync_q;    // select pin stages
  reg  [`QAS_SYNC_STAGES-1:0] sclk_sync_q;  // serial clock stages
  reg  [`QAS_SYNC_STAGES-1:0] din_sync_q;   // data-in stages
  reg                         cs_lvl_q;     // accepted select level
  reg                         sclk_lvl_q;   // accepted clock level
  reg                         din_lvl_q;    // accepted data level

  // sequencer state
  // counts are five bits so that sixteen fits and saturates
  reg  [4:0]                  fcnt_q;       // falls seen in conversion
  reg  [4:0]                  rcnt_q;       // rises seen in conversion
  reg                         active_q;     // inside a frame
  reg  [`QAS_CW_W-1:0]        cw_q;         // control word shifter
  reg  [1:0]                  next_chan_q;  // channel for next conversion

  // decoded edge events
  // a pin counts as settled once stages two and three agree; one more
  // stage of latency is traded for margin against a metastable sample
  wire cs_agree   = (cs_sync_q[1] == cs_sync_q[2]);
  wire sclk_agree = (sclk_sync_q[1] == sclk_sync_q[2]);
  wire din_agree  = (din_sync_q[1] == din_sync_q[2]);
  // an edge is a settled stage that differs from the accepted level
  wire cs_fall    = cs_agree & cs_lvl_q & ~cs_sync_q[2];
  wire cs_rise    = cs_agree & ~cs_lvl_q & cs_sync_q[2];
  wire sclk_fall  = sclk_agree & sclk_lvl_q & ~sclk_sync_q[2];
  wire sclk_rise  = sclk_agree & ~sclk_lvl_q & sclk_sync_q[2];

  // internal clock: edges only count while selected
  // a select rise wins over a clock edge of the same cycle, so a frame
  // that is cut short never starts or steps a conversion on its way out
  // inside a frame a real fall counts; with the clock parked high this
  // makes the first fall after select the start of track
  wire int_fall = active_q ? (sclk_fall & ~cs_rise)
                           : (cs_fall & ~sclk_lvl_q);
  // rises only matter inside a frame
  wire int_rise = active_q & sclk_rise & ~cs_rise;
  // frame still open after this cycle
  wire in_frame = active_q & ~cs_rise;

  // a new conversion starts on the first fall or after 16 rises
  // a fall that comes before the sixteenth rise only moves the count,
  // so a host that shortens a word cannot start a new sample early
  wire conv_start = int_fall &
                    ((fcnt_q == 5'h00) ||
                     (rcnt_q == `QAS_EDGES_PER_CONV));
  // number that this fall carries within its conversion
  wire [4:0] fcnt_nx = conv_start ? 5'h01 : (fcnt_q + 5'h01);

  // sar engine events
  // sample at fall four, then one decision per fall five to sixteen
  // the engine ignores a step before its first start after reset
  wire sar_start = int_fall & ~conv_start &
                   (fcnt_nx == `QAS_HOLD_FALL);
  wire sar_step  = int_fall & ~conv_start &
                   (fcnt_nx >= `QAS_FIRST_DATA_FALL) &
                   (fcnt_nx <= `QAS_EDGES_PER_CONV);

  // control word with the incoming bit shifted in, msb first
  // din is read as its settled level, taken on accepted rises one to eight
  wire [`QAS_CW_W-1:0] cw_nx = {cw_q[`QAS_CW_W-2:0], din_lvl_q};

  // pin synchronisers: first stage feeds only the second stage
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      // an idle host: deselected, clock parked low
      cs_sync_q   <= {`QAS_SYNC_STAGES{1'b1}};
      sclk_sync_q <= {`QAS_SYNC_STAGES{1'b0}};
      din_sync_q  <= {`QAS_SYNC_STAGES{1'b0}};
    end
    else
    begin
      // one stage per cycle; the pins arrive raw
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      din_sync_q  <= {din_sync_q[1:0], din};
    end
  end

  // accepted levels move only once stages two and three agree
  // a pulse narrower than two cycles on any pin is never accepted
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      cs_lvl_q   <= 1'b1;
      sclk_lvl_q <= 1'b0;
      din_lvl_q  <= 1'b0;
    end
    else
    begin
      // a pin still moving keeps its old level
      if (cs_agree)
        cs_lvl_q <= cs_sync_q[2];
      if (sclk_agree)
        sclk_lvl_q <= sclk_sync_q[2];
      if (din_agree)
        din_lvl_q <= din_sync_q[2];
    end
  end

  // frame tracking and edge counting
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      active_q <= 1'b0;
      fcnt_q   <= 5'h00;
      rcnt_q   <= 5'h00;
    end
    else if (cs_rise)
    begin
      // frame over: drop counts, next frame starts fresh
      active_q <= 1'b0;
      fcnt_q   <= 5'h00;
      rcnt_q   <= 5'h00;
    end
    else
    begin
      // select fall opens the frame
      if (cs_fall)
        active_q <= 1'b1;
      if (conv_start)
      begin
        // back-to-back conversions while select stays low
        fcnt_q <= 5'h01;
        rcnt_q <= 5'h00;
      end
      else
      begin
        // counting saturates; extra edges beyond a word are ignored
        if (int_fall && (fcnt_q < `QAS_EDGES_PER_CONV))
          fcnt_q <= fcnt_nx;
        // the sixteenth rise arms the next conversion start
        if (int_rise && (rcnt_q < `QAS_EDGES_PER_CONV))
          rcnt_q <= rcnt_q + 5'h01;
      end
    end
  end

  // control word capture and channel hand-off
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      // power-up: input one selected, no word pending
      cw_q        <= `QAS_CW_RESET;
      next_chan_q <= `QAS_CH_RESET;
      chan_sel    <= `QAS_CH_RESET;
    end
    else
    begin
      // only rises one to eight carry the word; the rest are ignored
      if (int_rise && (rcnt_q < `QAS_CTRL_BITS))
      begin
        cw_q <= cw_nx;
        // word complete on the eighth rise: hold for next conversion
        if (rcnt_q == (`QAS_CTRL_BITS - 5'h01))
          next_chan_q <= chan_of(cw_nx);
      end
      // the mux moves only as a new track phase begins
      if (conv_start)
        chan_sel <= next_chan_q;
    end
  end

  // track/hold, power and output enable
  // the output enable follows select; the core wakes only at fall one
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      // power-up: asleep and released until the first frame
      track         <= 1'b0;
      sample_strobe <= 1'b0;
      power_down    <= 1'b1;
      dout_oe_n     <= 1'b1;
    end
    else
    begin
      // one cycle wide, since sar_start is a single-cycle event
      sample_strobe <= sar_start;
      if (!in_frame && !cs_fall)
      begin
        // deselected: output released and core asleep
        dout_oe_n  <= 1'b1;
        power_down <= 1'b1;
        track      <= 1'b0;
      end
      else
      begin
        // selected, or select just fell: drive the line
        dout_oe_n <= 1'b0;
        if (conv_start)
        begin
          // track phase spans falls one to four
          track      <= 1'b1;
          power_down <= 1'b0;
        end
        // hold/convert from fall four through fall sixteen
        else if (sar_start)
          track <= 1'b0;
        // fall sixteen: asleep until the next fall one
        else if (int_fall &&
                 (fcnt_nx == `QAS_EDGES_PER_CONV))
          power_down <= 1'b1;
      end
    end
  end

  // serial output: four zeros, then decisions as they are made
  // limitation: each bit is the live comparator decision, so the core
  // must hold cmp_in settled from one step to the next
  always @(posedge sys_clk)
  begin
    if (reset)
      dout_o <= 1'b0;
    else if (cs_rise)
      dout_o <= 1'b0;
    else if (sar_step)
      dout_o <= cmp_in;
    else if (conv_start)
      dout_o <= 1'b0;
  end

  // bit engine; straight binary falls out of the msb-first search
  // it runs on the same enables, so no second clock is needed
  qas_sar u_sar
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .start      (sar_start),
    .step       (sar_step),
    .cmp_in     (cmp_in),
    .trial_code (dac_code),
    .result     (result),
    .done       (result_valid)
  );

endmodule
`default_nettype wire

// ---- verif/qas_seq_properties.sv ----
// Purpose : concurrent checks on the sequencer ports
// Assumes : sclk period of at least eight sys_clk cycles
// Notes   : pin edges take up to four cycles to reach the outputs
`timescale 1ns/1ps
`default_nettype none
`include "qas_consts.vh"

module qas_seq_properties
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  reset,
  // serial link
  input wire logic                  cs_n,
  input wire logic                  sclk,
  input wire logic                  din,
  input wire logic                  dout_o,
  input wire logic                  dout_oe_n,
  // analog core
  input wire logic                  cmp_in,
  input wire logic [1:0]            chan_sel,
  input wire logic                  track,
  input wire logic                  sample_strobe,
  input wire logic                  power_down,
  input wire logic [`QAS_RES_W-1:0] dac_code,
  // result
  input wire logic [`QAS_RES_W-1:0] result,
  input wire logic                  result_valid
);
  // one domain, so clock and reset are given once
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  chk_oe_idle: assert property (cs_n [*6] |=> dout_oe_n)
    else $error("dout driven while deselected");
  chk_oe_framed: assert property (!cs_n [*6] |=> !dout_oe_n)
    else $error("dout idle while selected");
  chk_power_idle: assert property (cs_n [*6] |=> power_down)
    else $error("core awake while deselected");
  chk_track_quiet: assert property (
    track |-> !power_down && !dout_o)
    else $error("track phase with power down or data bit");
  chk_track_span: assert property ($rose(track) |-> track [*8])
    else $error("track phase shorter than one serial clock");
  chk_hold_entry: assert property (
    $fell(track) |-> sample_strobe && dac_code == `QAS_SAR_SEED)
    else $error("hold entered without sample or seed code");
  chk_hold_span: assert property ($fell(track) |=> !track [*8])
    else $error("hold phase shorter than one serial clock");
  chk_strobe_pulse: assert property (
    sample_strobe |=> !sample_strobe [*8])
    else $error("second sample too soon");
  chk_end_power: assert property (
    $rose(power_down) && !cs_n |-> result_valid ##1 !result_valid)
    else $error("no single result pulse at power down");
  chk_chan_start: assert property (
    $changed(chan_sel) |-> $rose(track))
    else $error("channel moved outside conversion start");
  chk_result_hold: assert property (
    $changed(result) |-> result_valid)
    else $error("result changed without valid");

  // main scenarios reached
  cov_frame: cover property ($fell(dout_oe_n));
  cov_hold: cover property (sample_strobe);
  cov_result: cover property (result_valid);
endmodule

bind qas_seq qas_seq_properties chk (.sys_clk(sys_clk), .reset(reset),
  .cs_n(cs_n), .sclk(sclk), .din(din), .dout_o(dout_o),
  .dout_oe_n(dout_oe_n), .cmp_in(cmp_in), .chan_sel(chan_sel),
  .track(track), .sample_strobe(sample_strobe), .power_down(power_down),
  .dac_code(dac_code), .result(result), .result_valid(result_valid));
`default_nettype wire

// ---- verif/qas_host.sv ----
// Purpose : host model driving the serial link and the analog levels
// Assumes : sclk half period of 4 sys_clk cycles (160 ns period)
// Notes   : a released dout reads as the inverse of its last level
`timescale 1ns/1ps
`default_nettype none

module qas_host
(
  // clock
  input  wire logic        sys_clk,
  // serial link
  output var  logic        cs_n = 1'b1,
  output var  logic        sclk = 1'b0,
  output var  logic        din  = 1'b0,
  input  wire logic        dout_o,
  input  wire logic        dout_oe_n,
  // analog core
  input  wire logic [1:0]  chan_sel,
  input  wire logic [11:0] dac_code,
  output wire logic        cmp_in
);
  logic [11:0] ain [4];       // input levels, set by the bench
  logic        last_q = 1'b0; // last driven dout level
  wire         dout_line = dout_oe_n ? ~last_q : dout_o;

  // comparator: selected level against the trial code
  assign cmp_in = (ain[chan_sel] >= dac_code);

  // remember the driven level so a released line cannot look right
  always @(posedge sys_clk)
    if (!dout_oe_n)
      last_q <= dout_o;

  // wait n system cycles
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one conversion; open starts a frame, idle_hi means sclk parked high
  task automatic conv(input logic open, input logic idle_hi,
                      input logic [7:0] word, output logic [15:0] got);
    for (int k = 1; k <= 16; k++)
    begin
      if (open && k == 1)
      begin
        cs_n <= 1'b0; // frame opens
        ticks(4);     // select-to-clock spacing kept
      end
      // a low-parked clock lets the select fall act as fall one
      if (!(open && k == 1 && !idle_hi))
        sclk <= 1'b0;
      din <= (k <= 8) ? word[8-k] : 1'($urandom); // word msb first
      ticks(4);
      sclk <= 1'b1;
      ticks(4);
      got = {got[14:0], dout_line};
    end
  endtask

  // close after whole conversions, then park the clock
  task automatic close(input logic park_hi);
    cs_n <= 1'b1;
    ticks(8);
    sclk <= park_hi;
    ticks(8);
  endtask
endmodule
`default_nettype wire

// ---- verif/qas_seq_bench.sv ----
// Purpose : self-checking bench for the serial conversion sequencer
// Assumes : host model drives the link; levels random per frame, extreme codes in frame two
// Notes   : expected word is four zeros then the selected level
`timescale 1ns/1ps
`default_nettype none

module qas_seq_bench;
  logic        sys_clk = 1'b0; // 50 MHz system clock
  logic        reset   = 1'b1; // power-up model
  wire         cs_n, sclk, din, dout_o, dout_oe_n, cmp_in;
  wire         track, sample_strobe, power_down, result_valid;
  wire [1:0]   chan_sel;
  wire [11:0]  dac_code, result;
  int          mismatches = 0; // failed comparisons
  int          tests_run  = 0; // all comparisons
  logic [1:0]  pend;           // channel of the coming conversion
  logic [7:0]  word;           // control word of this conversion
  logic [15:0] got;            // word shifted out
  int          n;

  always #10 sys_clk = ~sys_clk;

  qas_seq uut (.sys_clk(sys_clk), .reset(reset), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .cmp_in(cmp_in), .chan_sel(chan_sel), .track(track),
    .sample_strobe(sample_strobe), .power_down(power_down),
    .dac_code(dac_code), .result(result), .result_valid(result_valid));
  qas_host host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_o(dout_o), .dout_oe_n(dout_oe_n), .chan_sel(chan_sel),
    .dac_code(dac_code), .cmp_in(cmp_in));

  // compare and count
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // serial word: leading zeros then the level, msb first
  function automatic logic [15:0] exp_word(input logic [11:0] lvl);
    return {4'h0, lvl};
  endfunction

  // verdict and end of run
  task automatic finish_test;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a hang counts as a failure
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    finish_test;
  end

  // frames alternate clock park level; conversions per frame random
  initial
  begin
    void'($urandom(32'h5cac));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({15'h0, dout_oe_n}, 16'h1);
    check({15'h0, power_down}, 16'h1);
    check({14'h0, chan_sel}, 16'h0);
    pend = 2'h0;
    for (int f = 0; f < 8; f++)
    begin
      // frame two uses the extreme codes
      for (int i = 0; i < 4; i++)
        host.ain[i] <= (f == 1) ? {12{i[0]}} : 12'($urandom);
      n = 1 + $urandom_range(2);
      for (int c = 0; c < n; c++)
      begin
        word = 8'($urandom);
        word[4:3] = 2'(f + c); // sweep every channel code
        host.conv(c == 0, f[0], word, got);
        check(got, exp_word(host.ain[pend]));
        check({4'h0, result}, {4'h0, host.ain[pend]});
        check({14'h0, chan_sel}, {14'h0, pend});
        pend = word[4:3];
      end
      host.close(!f[0]);
      check({14'h0, dout_oe_n, power_down}, 16'h3);
    end
    finish_test;
  end
endmodule
`default_nettype wire
